// ---- shared/bwp_defs.svh ----
// constants for the buffer write and page program sequencer
`ifndef BWP_DEFS_SVH
`define BWP_DEFS_SVH
`define BWP_OP_LD1      8'h84
`define BWP_OP_LD2      8'h87
`define BWP_OP_PE1      8'h83
`define BWP_OP_PE2      8'h86
`define BWP_OP_PN1      8'h88
`define BWP_OP_PN2      8'h89
`define BWP_OP_LP1      8'h82
`define BWP_OP_LP2      8'h85
`define BWP_LAST_528    10'h20f
`define BWP_LAST_512    10'h1ff
`define BWP_BUF_WORDS   528
`define BWP_IDX_DATA    3'h4
`define BWP_CLK_NS      10
`define BWP_T_ER_NS     12000
`define BWP_T_P_NS      8000
`define BWP_ER_CYC      ((`BWP_T_ER_NS) / (`BWP_CLK_NS))
`define BWP_P_CYC       ((`BWP_T_P_NS) / (`BWP_CLK_NS))
`define BWP_HALF_CYC    4'h4
`define BWP_GAP_CYC     4'h8
`endif

// ---- shared/bwp_pkg.sv ----
// types and opcode helpers shared by both ends
`include "bwp_defs.svh"
package bwp_pkg;
   typedef enum logic [3:0] {
      SEQ_IDLE  = 4'h1,
      SEQ_ERASE = 4'h2,
      SEQ_PROG  = 4'h4,
      SEQ_WAIT  = 4'h8
   } bwp_seq_e;

   typedef enum logic [3:0] {
      HST_IDLE = 4'h1,
      HST_LOW  = 4'h2,
      HST_HIGH = 4'h4,
      HST_GAP  = 4'h8
   } bwp_hst_e;

   // opcodes that carry data into a buffer
   function automatic logic bwp_is_load(input logic [7:0] op);
      return op == `BWP_OP_LD1 || op == `BWP_OP_LD2 ||
             op == `BWP_OP_LP1 || op == `BWP_OP_LP2;
   endfunction : bwp_is_load

   // opcodes that start a page program on deselect
   function automatic logic bwp_is_prog(input logic [7:0] op);
      return op == `BWP_OP_PE1 || op == `BWP_OP_PE2 ||
             op == `BWP_OP_PN1 || op == `BWP_OP_PN2 ||
             op == `BWP_OP_LP1 || op == `BWP_OP_LP2;
   endfunction : bwp_is_prog

   function automatic logic bwp_is_erase(input logic [7:0] op);
      return op == `BWP_OP_PE1 || op == `BWP_OP_PE2 ||
             op == `BWP_OP_LP1 || op == `BWP_OP_LP2;
   endfunction : bwp_is_erase

   // second buffer selected
   function automatic logic bwp_is_buf2(input logic [7:0] op);
      return op == `BWP_OP_LD2 || op == `BWP_OP_PE2 ||
             op == `BWP_OP_PN2 || op == `BWP_OP_LP2;
   endfunction : bwp_is_buf2
endpackage : bwp_pkg

// ---- shared/bwp_if.sv ----
// serial link between host controller and flash sequencer
`timescale 1ns/1ps
interface bwp_if;
   logic cs_n;
   logic sck;
   logic si;
   modport dev  (input  cs_n, input  sck, input  si);
   modport host (output cs_n, output sck, output si);
endinterface : bwp_if

// ---- logic/bwp_shift.sv ----
// serial to byte shifter, msb first
`timescale 1ns/1ps
module bwp_shift (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   // bit stream
   input  wire logic       clr,
   input  wire logic       bit_en,
   input  wire logic       bit_in,
   // byte out
   output logic [7:0]      byte_q,
   output logic            done_q
);
   logic [2:0] cnt_q;
   logic [6:0] sr_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q  <= 3'h0;
         sr_q   <= 7'h00;
         byte_q <= 8'h00;
         done_q <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         if (clr) begin
            cnt_q <= 3'h0;
         end else if (bit_en) begin
            sr_q  <= {sr_q[5:0], bit_in};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
               byte_q <= {sr_q, bit_in};
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule : bwp_shift

// ---- logic/bwp_dev.sv ----
// flash side: buffer loads and buffer to page programming
`timescale 1ns/1ps
`include "bwp_defs.svh"
module bwp_dev
   import bwp_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   // serial link
   bwp_if.dev              link,
   // configuration
   input  wire logic       page_512,
   // main array port
   input  wire logic       mem_fail,
   output logic            mem_erase_q,
   output logic            mem_we_q,
   output logic [12:0]     mem_page_q,
   output logic [9:0]      mem_col_q,
   output logic [7:0]      mem_data_q,
   // status
   output logic            busy_q,
   output logic            erase_program_error_flag_q
);
   localparam logic [11:0] ER_LAST = 12'(`BWP_ER_CYC - 1);
   localparam logic [11:0] P_LAST  = 12'(`BWP_P_CYC - 1);

   logic [7:0] buf1 [0:`BWP_BUF_WORDS-1];
   logic [7:0] buf2 [0:`BWP_BUF_WORDS-1];

   logic       cs_s1_q, cs_s2_q, cs_prev_q;
   logic       sck_s1_q, sck_s2_q, sck_prev_q;
   logic       si_s1_q, si_s2_q;
   logic [7:0] rx_byte;
   logic       rx_done;
   logic [2:0] idx_q;
   logic [7:0] op_q;
   logic [23:0] addr_q;
   logic [9:0] wptr_q;
   logic [9:0] rptr_q;
   logic [11:0] tim_q;
   logic       src_q;
   logic       cfg_q;
   bwp_seq_e   st_q;

   // offset and page fields of the three address bytes
   function automatic logic [9:0] off_of(input logic [23:0] a,
                                         input logic p5);
      return p5 ? {1'b0, a[8:0]} : a[9:0];
   endfunction : off_of

   function automatic logic [12:0] page_of(input logic [23:0] a,
                                           input logic p5);
      return p5 ? a[21:9] : a[22:10];
   endfunction : page_of

   function automatic logic [9:0] last_of(input logic p5);
      return p5 ? `BWP_LAST_512 : `BWP_LAST_528;
   endfunction : last_of

   wire        sck_rise  = sck_s2_q & ~sck_prev_q & ~cs_s2_q;
   wire        cs_rise   = cs_s2_q & ~cs_prev_q;
   wire [23:0] addr_new  = {addr_q[15:0], rx_byte};
   wire        in_data   = idx_q == `BWP_IDX_DATA;
   wire        hit_busy  = busy_q & (bwp_is_buf2(op_q) == src_q);
   wire        wr_en     = rx_done & in_data & bwp_is_load(op_q) &
                           ~hit_busy;
   wire [9:0]  wptr_nxt  = (wptr_q == last_of(page_512)) ? 10'h000 :
                           wptr_q + 10'h001;
   wire        go        = cs_rise & in_data & bwp_is_prog(op_q) &
                           ~busy_q;
   wire [7:0]  rd_byte   = src_q ? buf2[rptr_q] : buf1[rptr_q];
   wire        rd_last   = rptr_q == last_of(cfg_q);
   wire        tim_er    = tim_q == ER_LAST;
   wire        tim_p     = tim_q >= P_LAST;

   bwp_shift u_shift (
      .mclk   (mclk),
      .rst    (rst),
      .ce     (ce),
      .clr    (cs_s2_q),
      .bit_en (sck_rise),
      .bit_in (si_s2_q),
      .byte_q (rx_byte),
      .done_q (rx_done)
   );

   // pin synchronisers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cs_s1_q    <= 1'b1;
         cs_s2_q    <= 1'b1;
         cs_prev_q  <= 1'b1;
         sck_s1_q   <= 1'b0;
         sck_s2_q   <= 1'b0;
         sck_prev_q <= 1'b0;
         si_s1_q    <= 1'b0;
         si_s2_q    <= 1'b0;
      end else if (ce) begin
         cs_s1_q    <= link.cs_n;
         cs_s2_q    <= cs_s1_q;
         cs_prev_q  <= cs_s2_q;
         sck_s1_q   <= link.sck;
         sck_s2_q   <= sck_s1_q;
         sck_prev_q <= sck_s2_q;
         si_s1_q    <= link.si;
         si_s2_q    <= si_s1_q;
      end
   end

   // command, address and data pointer capture
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idx_q  <= 3'h0;
         op_q   <= 8'h00;
         addr_q <= 24'h000000;
         wptr_q <= 10'h000;
      end else if (ce) begin
         if (cs_s2_q) begin
            idx_q <= 3'h0;
         end else if (rx_done) begin
            if (!in_data) begin
               idx_q <= idx_q + 3'h1;
            end
            if (idx_q == 3'h0) begin
               op_q <= rx_byte;
            end else if (!in_data) begin
               addr_q <= addr_new;
            end
            if (idx_q == 3'h3) begin
               wptr_q <= off_of(addr_new, page_512);
            end else if (wr_en) begin
               wptr_q <= wptr_nxt;
            end
         end
      end
   end

   // buffer storage
   always_ff @(posedge mclk) begin
      if (ce && wr_en) begin
         if (bwp_is_buf2(op_q)) begin
            buf2[wptr_q] <= rx_byte;
         end else begin
            buf1[wptr_q] <= rx_byte;
         end
      end
   end

   // self-timed erase and program sequence
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q        <= SEQ_IDLE;
         busy_q      <= 1'b0;
         erase_program_error_flag_q <= 1'b0;
         src_q       <= 1'b0;
         cfg_q       <= 1'b0;
         tim_q       <= 12'h000;
         rptr_q      <= 10'h000;
         mem_erase_q <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_page_q  <= 13'h0000;
         mem_col_q   <= 10'h000;
         mem_data_q  <= 8'h00;
      end else if (ce) begin
         mem_erase_q <= 1'b0;
         mem_we_q    <= 1'b0;
         tim_q       <= tim_q + 12'h001;
         if (busy_q && mem_fail) begin
            erase_program_error_flag_q <= 1'b1;
         end
         case (st_q)
            SEQ_IDLE: begin
               tim_q  <= 12'h000;
               rptr_q <= 10'h000;
               if (go) begin
                  busy_q     <= 1'b1;
                  erase_program_error_flag_q <= 1'b0;
                  src_q      <= bwp_is_buf2(op_q);
                  cfg_q      <= page_512;
                  mem_page_q <= page_of(addr_q, page_512);
                  if (bwp_is_erase(op_q)) begin
                     mem_erase_q <= 1'b1;
                     st_q        <= SEQ_ERASE;
                  end else begin
                     st_q <= SEQ_PROG;
                  end
               end
            end
            SEQ_ERASE: begin
               if (tim_er) begin
                  tim_q <= 12'h000;
                  st_q  <= SEQ_PROG;
               end
            end
            SEQ_PROG: begin
               mem_we_q   <= 1'b1;
               mem_col_q  <= rptr_q;
               mem_data_q <= rd_byte;
               rptr_q     <= rptr_q + 10'h001;
               if (rd_last) begin
                  st_q <= SEQ_WAIT;
               end
            end
            SEQ_WAIT: begin
               if (tim_p) begin
                  busy_q <= 1'b0;
                  st_q   <= SEQ_IDLE;
               end
            end
            default: begin
               busy_q <= 1'b0;
               st_q   <= SEQ_IDLE;
            end
         endcase
      end
   end
endmodule : bwp_dev

// ---- logic/bwp_host.sv ----
// host side: drives chip select, clock and serial data
`timescale 1ns/1ps
`include "bwp_defs.svh"
module bwp_host
   import bwp_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   // serial link
   bwp_if.host             link,
   // command request
   input  wire logic       start,
   input  wire logic [7:0] op,
   input  wire logic [12:0] page,
   input  wire logic [9:0] offset,
   input  wire logic       page_512,
   input  wire logic [9:0] len,
   input  wire logic [7:0] wr_data,
   // status
   output logic            wr_take_q,
   output logic            idle_q
);
   logic       cs_n_q, sck_q, si_q;
   logic [7:0] sr_q;
   logic [2:0] bit_q;
   logic [2:0] byte_q;
   logic [9:0] left_q;
   logic [23:0] addr_q;
   logic [3:0] cnt_q;
   bwp_hst_e   st_q;

   // three address bytes for any supported opcode
   function automatic logic [23:0] pack_addr(input logic [7:0] o,
                                             input logic [12:0] pg,
                                             input logic [9:0] of,
                                             input logic p5);
      logic [12:0] p;
      logic [9:0]  f;
      p = bwp_is_prog(o) ? pg : 13'h0000;
      f = bwp_is_load(o) ? of : 10'h000;
      return p5 ? {2'b00, p, f[8:0]} :
                  {1'b0, p, f};
   endfunction : pack_addr

   wire half_done = cnt_q == `BWP_HALF_CYC - 4'h1;
   wire byte_end  = bit_q == 3'h7;
   wire more_addr = byte_q < 3'h3;
   wire more_data = left_q != 10'h000;

   assign link.cs_n = cs_n_q;
   assign link.sck  = sck_q;
   assign link.si   = si_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q      <= HST_IDLE;
         cs_n_q    <= 1'b1;
         sck_q     <= 1'b0;
         si_q      <= 1'b0;
         sr_q      <= 8'h00;
         bit_q     <= 3'h0;
         byte_q    <= 3'h0;
         left_q    <= 10'h000;
         addr_q    <= 24'h000000;
         cnt_q     <= 4'h0;
         wr_take_q <= 1'b0;
         idle_q    <= 1'b1;
      end else if (ce) begin
         wr_take_q <= 1'b0;
         cnt_q     <= cnt_q + 4'h1;
         case (st_q)
            HST_IDLE: begin
               if (start) begin
                  cs_n_q <= 1'b0;
                  idle_q <= 1'b0;
                  sr_q   <= op;
                  si_q   <= op[7];
                  addr_q <= pack_addr(op, page, offset, page_512);
                  left_q <= bwp_is_load(op) ? len : 10'h000;
                  bit_q  <= 3'h0;
                  byte_q <= 3'h0;
                  cnt_q  <= 4'h0;
                  st_q   <= HST_LOW;
               end
            end
            HST_LOW: begin
               if (half_done) begin
                  sck_q <= 1'b1;
                  cnt_q <= 4'h0;
                  st_q  <= HST_HIGH;
               end
            end
            HST_HIGH: begin
               if (half_done) begin
                  sck_q <= 1'b0;
                  cnt_q <= 4'h0;
                  bit_q <= bit_q + 3'h1;
                  st_q  <= HST_LOW;
                  si_q  <= sr_q[6];
                  sr_q  <= {sr_q[6:0], 1'b0};
                  if (byte_end) begin
                     byte_q <= more_addr ? byte_q + 3'h1 : byte_q;
                     if (more_addr) begin
                        sr_q   <= addr_q[23:16];
                        si_q   <= addr_q[23];
                        addr_q <= {addr_q[15:0], 8'h00};
                     end else if (more_data) begin
                        sr_q      <= wr_data;
                        si_q      <= wr_data[7];
                        wr_take_q <= 1'b1;
                        left_q    <= left_q - 10'h001;
                     end else begin
                        cs_n_q <= 1'b1;
                        si_q   <= 1'b0;
                        st_q   <= HST_GAP;
                     end
                  end
               end
            end
            HST_GAP: begin
               if (cnt_q == `BWP_GAP_CYC - 4'h1) begin
                  idle_q <= 1'b1;
                  st_q   <= HST_IDLE;
               end
            end
            default: begin
               cs_n_q <= 1'b1;
               idle_q <= 1'b1;
               st_q   <= HST_IDLE;
            end
         endcase
      end
   end
endmodule : bwp_host

// ---- verif/bwp_chk.sv ----
// concurrent checks on the serial link and the program sequencer
`timescale 1ns/1ps
module bwp_chk (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // serial link
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   // host and flash status
   input  wire logic       idle_q,
   input  wire logic       page_512,
   input  wire logic       mem_fail,
   input  wire logic       mem_erase_q,
   input  wire logic       mem_we_q,
   input  wire logic [9:0] mem_col_q,
   input  wire logic       busy_q,
   input  wire logic       erase_program_error_flag_q
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // length of the current busy run and whether it began with an erase
   logic [11:0] run_q;
   logic        er_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         run_q <= 12'h000;
         er_q  <= 1'b0;
      end else begin
         run_q <= busy_q ? run_q + 12'h001 : 12'h000;
         er_q  <= mem_erase_q | (er_q & busy_q);
      end
   end

   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("serial clock high outside a frame");
   a_sck_half_len: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
      else $error("serial clock high phase not four cycles");
   a_si_hold_high: assert property (sck |-> $stable(si))
      else $error("serial data moved while clock high");
   a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n[*3])
      else $error("chip select gap too short");
   a_frame_not_idle: assert property ($fell(cs_n) |->
      $past(idle_q) && !idle_q)
      else $error("frame opened while host was not idle");
   a_busy_after_cs: assert property ($rose(busy_q) |->
      $past(cs_n, 3) && !$past(cs_n, 6))
      else $error("busy rose without a recent chip select rise");
   a_erase_at_start: assert property (mem_erase_q |-> $rose(busy_q))
      else $error("erase pulse not at program start");
   a_write_in_busy: assert property (mem_we_q |->
      busy_q && !mem_erase_q)
      else $error("array write outside busy");
   a_col_first: assert property ($rose(mem_we_q) |->
      mem_col_q == 10'h000)
      else $error("program did not start at column zero");
   a_col_step: assert property (mem_we_q && $past(mem_we_q) |->
      mem_col_q == $past(mem_col_q) + 10'h001)
      else $error("program column did not advance by one");
   a_col_last: assert property ($fell(mem_we_q) |->
      $past(mem_col_q) == (page_512 ? 10'h1ff : 10'h20f))
      else $error("program did not end at last column");
   a_error_set: assert property (mem_fail && busy_q |=>
      erase_program_error_flag_q)
      else $error("array failure not flagged");
   a_busy_time: assert property ($fell(busy_q) |-> (er_q ?
      (run_q >= 12'h7ce && run_q <= 12'h7d2) :
      (run_q >= 12'h31e && run_q <= 12'h322)))
      else $error("busy run length wrong");
endmodule : bwp_chk

// ---- verif/bwp_tb.sv ----
// self-checking bench joining the host and flash ends back to back
`timescale 1ns/1ps
module bwp_tb;
   logic        mclk     = 1'b0;
   logic        rst      = 1'b1;
   logic        start    = 1'b0;
   logic [7:0]  op       = 8'h00;
   logic [12:0] page     = 13'h0000;
   logic [9:0]  offset   = 10'h000;
   logic        page_512 = 1'b0;
   logic [9:0]  len      = 10'h000;
   logic [7:0]  wr_data  = 8'h00;
   logic        mem_fail = 1'b0;
   logic        wr_take_q;
   logic        idle_q;
   logic        mem_erase_q;
   logic        mem_we_q;
   logic [12:0] mem_page_q;
   logic [9:0]  mem_col_q;
   logic [7:0]  mem_data_q;
   logic        busy_q;
   logic        erase_program_error_flag;
   int          seed;
   int          num_errors = 0;
   int          cmp_count  = 0;
   int          cyc        = 0;
   int          didx       = 0;
   int          wcnt       = 0;
   int          ecnt       = 0;
   logic [7:0]  dat [0:31];
   logic [7:0]  bm [0:1][0:527];
   bit          vm [0:1][0:527];
   logic [7:0]  got [0:527];
   logic [12:0] gpage;

   always #5 mclk = ~mclk;

   bwp_if link_if ();
   bwp_host i_bwp_host (.mclk(mclk), .rst(rst), .ce(1'b1), .link(link_if),
      .start(start), .op(op), .page(page), .offset(offset),
      .page_512(page_512), .len(len), .wr_data(wr_data),
      .wr_take_q(wr_take_q), .idle_q(idle_q));
   bwp_dev i_bwp_dev (.mclk(mclk), .rst(rst), .ce(1'b1), .link(link_if),
      .page_512(page_512), .mem_fail(mem_fail), .mem_erase_q(mem_erase_q),
      .mem_we_q(mem_we_q), .mem_page_q(mem_page_q), .mem_col_q(mem_col_q),
      .mem_data_q(mem_data_q), .busy_q(busy_q),
      .erase_program_error_flag_q(erase_program_error_flag));
   bwp_chk i_bwp_chk (.mclk(mclk), .rst(rst), .cs_n(link_if.cs_n),
      .sck(link_if.sck), .si(link_if.si), .idle_q(idle_q),
      .page_512(page_512), .mem_fail(mem_fail), .mem_erase_q(mem_erase_q),
      .mem_we_q(mem_we_q), .mem_col_q(mem_col_q), .busy_q(busy_q),
      .erase_program_error_flag_q(erase_program_error_flag));

   // feeds data bytes and captures array traffic
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (mem_we_q === 1'b1) begin
         got[mem_col_q] <= mem_data_q;
         gpage          <= mem_page_q;
         wcnt           <= wcnt + 1;
      end
      if (mem_erase_q === 1'b1) begin
         ecnt <= ecnt + 1;
      end
      if (wr_take_q === 1'b1) begin
         didx    <= didx + 1;
         wr_data <= dat[didx + 1];
      end
      if (cyc == 60000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [12:0] exp,
                      input logic [12:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic send(input logic [7:0] opc, input logic [12:0] pg,
                       input logic [9:0] of, input int n);
      int k;
      for (k = 0; k < 100 && idle_q !== 1'b1; k++) begin
         @(posedge mclk);
      end
      op      <= opc;
      page    <= pg;
      offset  <= of;
      len     <= 10'(n);
      wr_data <= dat[0];
      didx    <= 0;
      start   <= 1'b1;
      @(posedge mclk);
      start   <= 1'b0;
      repeat (2) @(posedge mclk);
      for (k = 0; k < 3000 && idle_q !== 1'b1; k++) begin
         @(posedge mclk);
      end
      chk("idle", 13'h0001, 13'(idle_q));
   endtask : send

   // one command; program commands are checked against the buffer model
   task automatic cmd(input logic [7:0] opc, input logic [12:0] pg,
                      input logic [9:0] of, input int n, input bit fail,
                      input bit dup);
      int k;
      int sz;
      int w0;
      int e0;
      bit b;
      bit ld;
      bit pr;
      bit er;
      sz = page_512 ? 512 : 528;
      b  = opc inside {8'h87, 8'h86, 8'h89, 8'h85};
      ld = opc inside {8'h84, 8'h87, 8'h82, 8'h85};
      pr = opc inside {8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85};
      er = opc inside {8'h83, 8'h86, 8'h82, 8'h85};
      for (k = 0; k < n; k++) begin
         dat[k] = 8'($random(seed));
         if (ld) begin
            bm[b][(of + k) % sz] = dat[k];
            vm[b][(of + k) % sz] = 1'b1;
         end
      end
      w0 = wcnt;
      e0 = ecnt;
      send(opc, pg, of, n);
      if (pr) begin
         chk("busy", 13'h0001, 13'(busy_q));
         if (fail) begin
            mem_fail <= 1'b1;
            @(posedge mclk);
            mem_fail <= 1'b0;
         end
         if (dup) begin
            send(8'h89, pg + 13'h0001, 10'h000, 0);
         end
         for (k = 0; k < 2200 && busy_q !== 1'b0; k++) begin
            @(posedge mclk);
         end
         chk("busy end", 13'h0000, 13'(busy_q));
         @(posedge mclk);
         chk("writes", 13'(sz), 13'(wcnt - w0));
         chk("erases", 13'(er), 13'(ecnt - e0));
         chk("page", pg, gpage);
         chk("error", 13'(fail), 13'(erase_program_error_flag));
         for (k = 0; k < sz; k++) begin
            if (vm[b][k]) begin
               chk("data", 13'(bm[b][k]), 13'(got[k]));
            end
         end
      end else if (!ld) begin
         chk("stray busy", 13'h0000, 13'(busy_q));
      end
      $display("command %h done", opc);
   endtask : cmd

   initial begin
      seed = 32'hd626;
      vm   = '{default: 1'b0};
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      // 528-byte pages: a wrapping load and a plain load, then each program opcode
      cmd(8'h84, 13'h0000, 10'h20c, 9, 0, 0);
      cmd(8'h87, 13'h1555, 10'h000, 12, 0, 0);
      cmd(8'h83, 13'h1fff, 10'h000, 0, 1, 1);
      cmd(8'h86, 13'h0a5a, 10'h3ff, 0, 0, 0);
      cmd(8'h88, 13'h1fff, 10'h000, 0, 0, 0);
      cmd(8'h89, 13'h0a5a, 10'h000, 0, 0, 0);
      cmd(8'h82, 13'($random(seed)), 10'h20e, 5, 0, 0);
      cmd(8'h85, 13'($random(seed)), 10'($unsigned($random(seed)) % 528),
          1 + $unsigned($random(seed)) % 16, 0, 0);
      // 512-byte pages
      page_512 <= 1'b1;
      vm = '{default: 1'b0};
      @(posedge mclk);
      cmd(8'h84, 13'h0000, 10'h1fd, 7, 0, 0);
      cmd(8'h88, 13'($random(seed)), 10'h000, 0, 1, 0);
      cmd(8'h85, 13'h1fff, 10'h1ff, 4, 0, 0);
      cmd(8'h81, 13'h0001, 10'h000, 0, 0, 0);
      end_of_test();
   end
endmodule : bwp_tb
